// ==== psrpc_ctrl.v ====
// strap decode, reset sequencing, power modes and management register slave
`include "psrpc_regs.vh"
`default_nettype none

module psrpc_ctrl (
    // clock and power-on reset
    input  wire        clk,
    input  wire        arst_n,
    // hardware reset pin, synchronous
    input  wire        hw_reset_n,
    // board straps
    input  wire        pkg_64pin,
    input  wire        speed_advert_strap,
    input  wire [2:0]  tx_skew_strap,
    input  wire [2:0]  rx_skew_strap,
    input  wire [3:0]  led_strap,
    input  wire [4:0]  mgmt_address_strap,
    // management bus
    input  wire        mdc,
    input  wire        mdio_in,
    output reg         mdio_out,
    output reg         mdio_oe,
    // power control pins and status
    input  wire        power_down_input_low,
    input  wire        link_partner_seen,
    output wire        power_down,
    output wire        crystal_pad_off,
    output wire        sleep_powered_off,
    output wire        nlp_enable,
    // reset outputs to the transceiver circuits
    output wire        core_reset,
    output wire        core_restart,
    // decoded strap settings
    output reg         adv_10,
    output reg         adv_100,
    output reg         adv_1000,
    output reg  [11:0] tx_skew_ps,
    output reg  [11:0] rx_skew_ps,
    output reg  [4:0]  mgmt_addr,
    // indicators
    input  wire [15:0] led_events,
    output reg         indicator_out_zero,
    output reg         indicator_out_one,
    output reg         indicator_out_two,
    output reg         indicator_out_three
);
    ////////////////////////////////////////////////////////////////////////
    // constants and functions
    localparam [9:0] POR_CYC   = `PSRPC_POR_CYC;   // power-on hold time
    localparam [9:0] SWRST_CYC = `PSRPC_SWRST_CYC; // software reset duration
    // one-hot frame states
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_HDR  = 4'h2;
    localparam [3:0] ST_TA   = 4'h4;
    localparam [3:0] ST_DATA = 4'h8;
    // skew code to picoseconds, shared by both directions
    function [11:0] skew_ps;
        input [2:0] code;
        begin
            case (code)
                3'h0:    skew_ps = 12'd2000;
                3'h1:    skew_ps = 12'd1500;
                3'h2:    skew_ps = 12'd1000;
                3'h3:    skew_ps = 12'd500;
                3'h4:    skew_ps = 12'd0;
                3'h5:    skew_ps = 12'd3500;
                3'h6:    skew_ps = 12'd3000;
                default: skew_ps = 12'd2500;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // declarations
    reg  [9:0]  por_cnt;      // counts down the internal power-on hold
    reg  [9:0]  std_cnt, grst_cnt, rst_cnt; // standard, global and restart busy counts
    reg  [3:0]  led_pol;      // 1 = active-low driver
    reg  [15:0] bmc;          // basic_mode_control
    reg  [15:0] phy_configuration, led_function_select;
    reg         mdc_q;        // previous management clock level
    reg  [3:0]  state;        // frame state
    reg  [5:0]  pre_cnt;      // preamble ones seen
    reg  [4:0]  cnt;          // bit counter within a field
    reg  [13:0] hdr;          // start, op, address, register
    reg  [4:0]  reg_addr;     // register of the current frame
    reg         is_rd;        // current frame is a read
    reg  [15:0] shift;        // read or write data shifter
    reg         wr_stb;       // one-cycle register write pulse
    reg  [15:0] wr_data;      // data of that write
    reg  [15:0] rd_mux;       // read data for reg_addr

    wire        hw_rst    = (por_cnt != 10'd0) | ~hw_reset_n;
    wire        std_busy  = (std_cnt != 10'd0);
    wire        grst_busy = (grst_cnt != 10'd0);
    wire        mdc_rise  = mdc & ~mdc_q;
    wire [13:0] next_hdr  = {hdr[12:0], mdio_in};
    wire [1:0]  slp       = phy_configuration[`PSRPC_PHYCFG_SLP_HI:`PSRPC_PHYCFG_SLP_LO];
    wire        in_sleep  = (slp == `PSRPC_SLP_ACTIVE) | (slp == `PSRPC_SLP_PASSIVE);
    wire        addr_hit  = pkg_64pin ? (next_hdr[9:5] == mgmt_addr)
                                      : (next_hdr[8:5] == mgmt_addr[3:0]);

    ////////////////////////////////////////////////////////////////////////
    // power-on hold counter, loaded by the async reset only
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            por_cnt <= POR_CYC;
        end else if (por_cnt != 10'd0) begin
            por_cnt <= por_cnt - 10'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strap capture, sampled every hardware reset cycle so the value at release
    // is kept; software resets never reach here, so latched straps survive them
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            adv_10     <= 1'b1;
            adv_100    <= 1'b1;
            adv_1000   <= 1'b1;
            tx_skew_ps <= 12'd2000;
            rx_skew_ps <= 12'd2000;
            mgmt_addr  <= 5'h00;
            led_pol    <= 4'h0;
        end else if (hw_rst) begin
            adv_10     <= ~speed_advert_strap;
            adv_100    <= 1'b1;
            adv_1000   <= 1'b1;
            tx_skew_ps <= skew_ps(tx_skew_strap);
            rx_skew_ps <= skew_ps(rx_skew_strap);
            // narrow package sees only four address bits
            mgmt_addr  <= pkg_64pin ? mgmt_address_strap
                                    : {1'b0, mgmt_address_strap[3:0]};
            led_pol    <= led_strap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset sequencer counters
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            std_cnt  <= 10'd0;
            grst_cnt <= 10'd0;
            rst_cnt  <= 10'd0;
        end else if (hw_rst) begin
            std_cnt  <= 10'd0;
            grst_cnt <= 10'd0;
            rst_cnt  <= 10'd0;
        end else begin
            // standard reset: start on write of bit 15
            if (wr_stb && reg_addr == `PSRPC_BMC_ADDR && wr_data[`PSRPC_BMC_SWRST]) begin
                std_cnt <= SWRST_CYC;
            end else if (std_busy) begin
                std_cnt <= std_cnt - 10'd1;
            end
            // global reset and restart
            if (wr_stb && reg_addr == `PSRPC_GRC_ADDR && wr_data[`PSRPC_GRC_GRST]) begin
                grst_cnt <= SWRST_CYC;
            end else if (grst_busy) begin
                grst_cnt <= grst_cnt - 10'd1;
            end
            if (wr_stb && reg_addr == `PSRPC_GRC_ADDR && wr_data[`PSRPC_GRC_RESTART]) begin
                rst_cnt <= SWRST_CYC;
            end else if (rst_cnt != 10'd0) begin
                rst_cnt <= rst_cnt - 10'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register file
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bmc                 <= `PSRPC_BMC_RST_VAL;
            phy_configuration   <= `PSRPC_PHYCFG_RST_VAL;
            led_function_select <= `PSRPC_LEDSEL_RST_VAL;
        end else if (hw_rst || grst_busy) begin
            bmc                 <= `PSRPC_BMC_RST_VAL;
            phy_configuration   <= `PSRPC_PHYCFG_RST_VAL;
            led_function_select <= `PSRPC_LEDSEL_RST_VAL;
        end else begin
            if (std_busy) begin
                // only the standard register returns to default
                bmc <= `PSRPC_BMC_RST_VAL;
            end else if (wr_stb && reg_addr == `PSRPC_BMC_ADDR) begin
                bmc <= wr_data & `PSRPC_BMC_WR_MASK;
            end
            if (wr_stb && reg_addr == `PSRPC_PHYCFG_ADDR) begin
                phy_configuration <= wr_data;
            end
            if (wr_stb && reg_addr == `PSRPC_LEDSEL_ADDR) begin
                led_function_select <= wr_data;
            end
            // pin overrides a write that clears the bit, so it holds
            if (!power_down_input_low) begin
                bmc[`PSRPC_BMC_PDOWN] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; unmapped registers read zero
    always @* begin
        if (reg_addr == `PSRPC_BMC_ADDR) begin
            rd_mux = {std_busy, bmc[14:0]};
        end else if (reg_addr == `PSRPC_PHYCFG_ADDR) begin
            rd_mux = phy_configuration;
        end else if (reg_addr == `PSRPC_LEDSEL_ADDR) begin
            rd_mux = led_function_select;
        end else if (reg_addr == `PSRPC_GRC_ADDR) begin
            rd_mux = {grst_busy, rst_cnt != 10'd0, 14'h0000};
        end else begin
            rd_mux = 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // management frame slave; runs in every power mode so registers stay reachable
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mdc_q    <= 1'b0;
            state    <= ST_IDLE;
            pre_cnt  <= 6'd0;
            cnt      <= 5'd0;
            hdr      <= 14'h0000;
            reg_addr <= 5'h00;
            is_rd    <= 1'b0;
            shift    <= 16'h0000;
            wr_stb   <= 1'b0;
            wr_data  <= 16'h0000;
            mdio_out <= 1'b0;
            mdio_oe  <= 1'b0;
        end else if (hw_rst) begin
            mdc_q    <= mdc;
            state    <= ST_IDLE;
            pre_cnt  <= 6'd0;
            wr_stb   <= 1'b0;
            mdio_oe  <= 1'b0;
            mdio_out <= 1'b0;
        end else begin
            mdc_q  <= mdc;
            wr_stb <= 1'b0;
            if (mdc_rise) begin
                case (state)
                    ST_IDLE: begin
                        // a zero after a full preamble is the first start bit
                        if (mdio_in) begin
                            if (pre_cnt != `PSRPC_PREAMBLE_LEN) begin
                                pre_cnt <= pre_cnt + 6'd1;
                            end
                        end else begin
                            if (pre_cnt == `PSRPC_PREAMBLE_LEN) begin
                                state <= ST_HDR;
                                hdr   <= 14'h0000;
                                cnt   <= 5'd1;
                            end
                            pre_cnt <= 6'd0;
                        end
                    end
                    ST_HDR: begin
                        hdr <= next_hdr;
                        cnt <= cnt + 5'd1;
                        if (cnt == 5'd13) begin
                            cnt <= 5'd0;
                            // foreign addresses and bad opcodes are ignored
                            if (next_hdr[13:12] == 2'h1 && addr_hit &&
                                (next_hdr[11:10] == `PSRPC_OP_READ ||
                                 next_hdr[11:10] == `PSRPC_OP_WRITE)) begin
                                state    <= ST_TA;
                                reg_addr <= next_hdr[4:0];
                                is_rd    <= (next_hdr[11:10] == `PSRPC_OP_READ);
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_TA: begin
                        if (cnt == 5'd0) begin
                            // second turnaround bit driven low on a read
                            mdio_oe  <= is_rd;
                            mdio_out <= 1'b0;
                            shift    <= rd_mux;
                            cnt      <= 5'd1;
                        end else begin
                            mdio_out <= shift[15];
                            shift    <= {shift[14:0], 1'b0};
                            cnt      <= 5'd0;
                            state    <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        cnt <= cnt + 5'd1;
                        if (is_rd) begin
                            mdio_out <= shift[15];
                            shift    <= {shift[14:0], 1'b0};
                        end else begin
                            shift <= {shift[14:0], mdio_in};
                        end
                        if (cnt == 5'd15) begin
                            state    <= ST_IDLE;
                            mdio_oe  <= 1'b0;
                            mdio_out <= 1'b0;
                            wr_stb   <= ~is_rd;
                            wr_data  <= {shift[14:0], mdio_in};
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // indicator drivers; a strap pulled high at reset makes the pin sink current
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            indicator_out_zero  <= 1'b0;
            indicator_out_one   <= 1'b0;
            indicator_out_two   <= 1'b0;
            indicator_out_three <= 1'b0;
        end else begin
            indicator_out_zero  <= led_events[led_function_select[3:0]]   ^ led_pol[0];
            indicator_out_one   <= led_events[led_function_select[7:4]]   ^ led_pol[1];
            indicator_out_two   <= led_events[led_function_select[11:8]]  ^ led_pol[2];
            indicator_out_three <= led_events[led_function_select[15:12]] ^ led_pol[3];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power mode outputs
    // pin is ORed in directly so power-down starts the same cycle
    assign power_down        = bmc[`PSRPC_BMC_PDOWN] | ~power_down_input_low;
    assign crystal_pad_off   = power_down & phy_configuration[`PSRPC_PHYCFG_DEEP];
    // sleep wakes by itself once a partner appears
    assign sleep_powered_off = in_sleep & ~link_partner_seen;
    assign nlp_enable        = ~power_down & (slp != `PSRPC_SLP_PASSIVE);
    assign core_reset        = hw_rst | grst_busy | std_busy;
    assign core_restart      = (rst_cnt != 10'd0);
endmodule // psrpc_ctrl

`default_nettype wire

// ==== psrpc_regs.vh ====
// register offsets, field positions, reset values and timing counts for the strap/reset/power block
`ifndef PSRPC_REGS_VH
`define PSRPC_REGS_VH

// clock period
`define PSRPC_CLK_NS          20

// register offsets (management register numbers)
`define PSRPC_BMC_ADDR        5'h00
`define PSRPC_PHYCFG_ADDR     5'h10
`define PSRPC_LEDSEL_ADDR     5'h18
`define PSRPC_GRC_ADDR        5'h1F

// basic_mode_control fields
`define PSRPC_BMC_SWRST       15
`define PSRPC_BMC_PDOWN       11
`define PSRPC_BMC_RST_VAL     16'h1140
`define PSRPC_BMC_WR_MASK     16'h7FC0

// phy_configuration fields
`define PSRPC_PHYCFG_DEEP     7
`define PSRPC_PHYCFG_SLP_HI   9
`define PSRPC_PHYCFG_SLP_LO   8
`define PSRPC_PHYCFG_RST_VAL  16'h0000
`define PSRPC_SLP_ACTIVE      2'h2
`define PSRPC_SLP_PASSIVE     2'h3

// led_function_select reset value
`define PSRPC_LEDSEL_RST_VAL  16'h0000

// global_reset_control fields
`define PSRPC_GRC_GRST        15
`define PSRPC_GRC_RESTART     14

// timing: figures in ns, then the same spans as sized 20 ns clock counts
`define PSRPC_POR_NS          10000
`define PSRPC_HWRST_MIN_NS    1000
`define PSRPC_SWRST_NS        320
`define PSRPC_POR_CYC         10'h1F4
`define PSRPC_HWRST_MIN_CYC   10'h032
`define PSRPC_SWRST_CYC       10'h010

// management frame constants
`define PSRPC_PREAMBLE_LEN    6'd32
`define PSRPC_OP_READ         2'h2
`define PSRPC_OP_WRITE        2'h1

`endif

// ==== psrpc_ctrl_asserts.sv ====
// port-level assertions for the strap, reset and power block
`default_nettype none
module psrpc_ctrl_asserts (
    // clock and resets
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        hw_reset_n,
    // straps
    input wire logic        pkg_64pin,
    input wire logic        speed_advert_strap,
    input wire logic [2:0]  tx_skew_strap,
    input wire logic [2:0]  rx_skew_strap,
    input wire logic [4:0]  mgmt_address_strap,
    // pins and outputs
    input wire logic        mdio_oe,
    input wire logic        power_down_input_low,
    input wire logic        link_partner_seen,
    input wire logic        power_down,
    input wire logic        crystal_pad_off,
    input wire logic        sleep_powered_off,
    input wire logic        nlp_enable,
    input wire logic        core_reset,
    input wire logic        core_restart,
    input wire logic        adv_10,
    input wire logic [11:0] tx_skew_ps,
    input wire logic [11:0] rx_skew_ps,
    input wire logic [4:0]  mgmt_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    // skew code to delay in ps, both directions
    localparam logic [11:0] skew_tab [8] = '{12'h7D0, 12'h5DC, 12'h3E8, 12'h1F4, 12'h000, 12'hDAC, 12'hBB8, 12'h9C4};
    logic [9:0] por_cnt;  // cycles since release, saturating
    ////////////////////////////////////////////////////////////////////////
    // count cycles after power-on reset release
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            por_cnt <= 10'h000;
        end else if (por_cnt != 10'h3FF) begin
            por_cnt <= por_cnt + 10'h001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////
    // a few cycles of low pin, so a synchroniser in front does not matter
    sequence s_hw_low; !hw_reset_n [*3]; endsequence
    sequence s_restart_busy; core_restart [*8]; endsequence
    property p_por_hold; por_cnt < 10'h1EA |-> core_reset; endproperty
    a_por_hold: assert property (p_por_hold) else $error("reset gone early");
    property p_por_end; por_cnt == 10'h1F9 && hw_reset_n |-> !core_reset; endproperty
    a_por_end: assert property (p_por_end) else $error("reset stuck after power-up");
    property p_hw_hold; s_hw_low |-> core_reset && !mdio_oe; endproperty
    a_hw_hold: assert property (p_hw_hold) else $error("hw reset not held");
    property p_adv; s_hw_low |=> adv_10 == !$past(speed_advert_strap); endproperty
    a_adv: assert property (p_adv) else $error("speed strap decode");
    property p_tx; s_hw_low |=> tx_skew_ps == skew_tab[$past(tx_skew_strap)]; endproperty
    a_tx: assert property (p_tx) else $error("tx skew decode");
    property p_rx; s_hw_low |=> rx_skew_ps == skew_tab[$past(rx_skew_strap)]; endproperty
    a_rx: assert property (p_rx) else $error("rx skew decode");
    property p_addr;
        s_hw_low |=> mgmt_addr == ($past(mgmt_address_strap) & {$past(pkg_64pin), 4'hF});
    endproperty
    a_addr: assert property (p_addr) else $error("address latch");
    property p_pin_pd; !power_down_input_low |-> power_down; endproperty
    a_pin_pd: assert property (p_pin_pd) else $error("pin does not power down");
    property p_xtal; crystal_pad_off |-> power_down; endproperty
    a_xtal: assert property (p_xtal) else $error("pad off while up");
    property p_nlp; nlp_enable |-> !power_down; endproperty
    a_nlp: assert property (p_nlp) else $error("pulses while down");
    property p_sleep; sleep_powered_off |-> !link_partner_seen; endproperty
    a_sleep: assert property (p_sleep) else $error("asleep with partner");
    property p_restart; $rose(core_restart) |-> s_restart_busy ##1 s_restart_busy ##1 !core_restart; endproperty
    a_restart: assert property (p_restart) else $error("restart length");
endmodule // psrpc_ctrl_asserts
`default_nettype wire

// ==== psrpc_mdio_host.sv ====
// management host model: clocks frames and reads back over a pulled-up line
`default_nettype none
module psrpc_mdio_host (
    // bench clock
    input  wire logic clk,
    // device side of the data line
    input  wire logic mdio_oe,
    input  wire logic mdio_out,
    // host side
    output var logic  mdc,
    output wire logic mdio_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hdrv;  // host drives the line
    logic hbit;  // host bit value
    // device wins, else host, else pull-up so a released line reads one
    assign mdio_in = mdio_oe ? mdio_out : (hdrv ? hbit : 1'b1);
    initial begin
        mdc = 1'b0;
        hdrv = 1'b0;
        hbit = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // one frame, fresh preamble each time; mdc two clocks low, two high
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] bits;
        bits = {32'hFFFFFFFF, 2'h1, op, pa, ra, 2'h2, wd};
        rd = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            hdrv = !(op == 2'h2 && i < 18);  // let go from turnaround on reads
            hbit = bits[i];
            mdc = 1'b0;
            repeat (2) @(negedge clk);
            if (i < 16) begin
                rd = {rd[14:0], mdio_in};  // sampled just before the next rise
            end
            mdc = 1'b1;
            repeat (2) @(negedge clk);
        end
        hdrv = 1'b0;
    endtask
endmodule // psrpc_mdio_host
`default_nettype wire

// ==== tb_psrpc_ctrl.sv ====
// self-checking bench for the strap, reset and power-mode block
`include "psrpc_regs.vh"
`default_nettype none
module tb_psrpc_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    // strap inputs beside their decoded values
    typedef struct packed {
        logic spd; logic [2:0] tx; logic [2:0] rx; logic [3:0] led; logic pkg; logic [4:0] adr;
        logic [11:0] etx; logic [11:0] erx; logic [4:0] ead;
    } psrpc_row_t;
    localparam psrpc_row_t rows [8] = '{
        '{1'b0, 3'h0, 3'h7, 4'h0, 1'b1, 5'h1F, 12'h7D0, 12'h9C4, 5'h1F},
        '{1'b1, 3'h1, 3'h6, 4'hF, 1'b0, 5'h1F, 12'h5DC, 12'hBB8, 5'h0F},
        '{1'b0, 3'h2, 3'h5, 4'h5, 1'b0, 5'h09, 12'h3E8, 12'hDAC, 5'h09},
        '{1'b1, 3'h3, 3'h4, 4'hA, 1'b1, 5'h19, 12'h1F4, 12'h000, 5'h19},
        '{1'b0, 3'h4, 3'h3, 4'h1, 1'b0, 5'h10, 12'h000, 12'h1F4, 5'h00},
        '{1'b1, 3'h5, 3'h2, 4'h8, 1'b1, 5'h01, 12'hDAC, 12'h3E8, 5'h01},
        '{1'b0, 3'h6, 3'h1, 4'h3, 1'b1, 5'h00, 12'hBB8, 12'h5DC, 5'h00},
        '{1'b1, 3'h7, 3'h0, 4'h6, 1'b1, 5'h13, 12'h9C4, 12'h7D0, 5'h13}};
    logic        clk, arst_n, hw_reset_n, pkg_64pin, speed_advert_strap, mdc, mdio_in, mdio_out, mdio_oe;
    logic        power_down_input_low, link_partner_seen, power_down, crystal_pad_off, sleep_powered_off;
    logic        nlp_enable, core_reset, core_restart, adv_10, adv_100, adv_1000;
    logic [2:0]  tx_skew_strap, rx_skew_strap;
    logic [3:0]  led_strap, ind;
    logic [4:0]  mgmt_address_strap, mgmt_addr, pa;
    logic [11:0] tx_skew_ps, rx_skew_ps;
    logic [15:0] led_events, v;
    psrpc_row_t  r;
    int          fails, cmp_count;
    psrpc_ctrl i_dut (.clk(clk), .arst_n(arst_n), .hw_reset_n(hw_reset_n), .pkg_64pin(pkg_64pin),
        .speed_advert_strap(speed_advert_strap), .tx_skew_strap(tx_skew_strap), .rx_skew_strap(rx_skew_strap),
        .led_strap(led_strap), .mgmt_address_strap(mgmt_address_strap), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .power_down_input_low(power_down_input_low),
        .link_partner_seen(link_partner_seen), .power_down(power_down), .crystal_pad_off(crystal_pad_off),
        .sleep_powered_off(sleep_powered_off), .nlp_enable(nlp_enable), .core_reset(core_reset),
        .core_restart(core_restart), .adv_10(adv_10), .adv_100(adv_100), .adv_1000(adv_1000),
        .tx_skew_ps(tx_skew_ps), .rx_skew_ps(rx_skew_ps), .mgmt_addr(mgmt_addr), .led_events(led_events),
        .indicator_out_zero(ind[0]), .indicator_out_one(ind[1]), .indicator_out_two(ind[2]),
        .indicator_out_three(ind[3]));
    psrpc_mdio_host i_host (.clk(clk), .mdio_oe(mdio_oe), .mdio_out(mdio_out), .mdc(mdc), .mdio_in(mdio_in));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
        i_host.frame(2'h2, pa, ra, 16'h0000, v);
        chk(v, exp);
    endtask
    // write, then let the write pulse land
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        i_host.frame(2'h1, pa, ra, d, v);
        repeat (4) @(negedge clk);
    endtask
    // 60 clocks low, over the 1 us minimum; straps change mid-pulse
    task automatic hwrst(input psrpc_row_t x);
        hw_reset_n = 1'b0;
        repeat (3) @(negedge clk);
        {speed_advert_strap, tx_skew_strap, rx_skew_strap, led_strap, pkg_64pin, mgmt_address_strap} = x[45:29];
        repeat (57) @(negedge clk);
        hw_reset_n = 1'b1;
        repeat (3) @(negedge clk);
    endtask
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // watchdog, about three times the expected run
    initial begin
        #400000;
        fails++;
        test_done();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {arst_n, link_partner_seen, pkg_64pin, speed_advert_strap, tx_skew_strap, rx_skew_strap} = '0;
        {led_strap, mgmt_address_strap} = '0;
        {hw_reset_n, power_down_input_low} = 2'h3;
        led_events = 16'h0001;
        pa = 5'h13;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        repeat (520) @(negedge clk);
        chk(16'({core_reset, mgmt_addr}), 16'h0000);
        foreach (rows[i]) begin
            hwrst(rows[i]);
            chk(16'({adv_10, adv_100, adv_1000}), 16'({~rows[i].spd, 2'h3}));
            chk(16'(tx_skew_ps), 16'(rows[i].etx));
            chk(16'(rx_skew_ps), 16'(rows[i].erx));
            chk(16'(mgmt_addr), 16'(rows[i].ead));
            chk(16'(ind), 16'(4'hF ^ rows[i].led));
        end
        rd(`PSRPC_BMC_ADDR, 16'h1140);
        rd(`PSRPC_PHYCFG_ADDR, 16'h0000);
        rd(`PSRPC_LEDSEL_ADDR, 16'h0000);
        rd(`PSRPC_GRC_ADDR, 16'h0000);
        rd(5'h05, 16'h0000);
        pa = 5'h12;
        rd(`PSRPC_BMC_ADDR, 16'hFFFF);
        pa = 5'h13;
        wr(`PSRPC_LEDSEL_ADDR, 16'h4321);
        led_events = 16'h001A;
        repeat (2) @(negedge clk);
        chk(16'(ind), 16'(4'hD ^ rows[7].led));
        wr(`PSRPC_BMC_ADDR, 16'h0800);
        chk(16'(power_down), 16'h0001);
        rd(`PSRPC_BMC_ADDR, 16'h0800);
        wr(`PSRPC_BMC_ADDR, 16'h0000);
        chk(16'(power_down), 16'h0000);
        wr(`PSRPC_PHYCFG_ADDR, 16'h0080);
        power_down_input_low = 1'b0;
        wr(`PSRPC_BMC_ADDR, 16'h0000);
        rd(`PSRPC_BMC_ADDR, 16'h0800);
        power_down_input_low = 1'b1;
        chk(16'({power_down, crystal_pad_off}), 16'h0003);
        wr(`PSRPC_BMC_ADDR, 16'h8000);
        chk(16'(core_reset), 16'h0001);
        repeat (20) @(negedge clk);
        chk(16'({core_reset, power_down}), 16'h0000);
        rd(`PSRPC_BMC_ADDR, 16'h1140);
        rd(`PSRPC_PHYCFG_ADDR, 16'h0080);
        // each sleep field, partner absent then present
        for (int s = 0; s < 4; s++) begin
            wr(`PSRPC_PHYCFG_ADDR, 16'(s << 8));
            link_partner_seen = 1'b0;
            @(negedge clk);
            chk(16'({sleep_powered_off, nlp_enable}), 16'({s > 1, s != 3}));
            link_partner_seen = 1'b1;
            @(negedge clk);
            chk(16'(sleep_powered_off), 16'h0000);
        end
        wr(`PSRPC_GRC_ADDR, 16'h4000);
        chk(16'({core_restart, core_reset}), 16'h0002);
        repeat (20) @(negedge clk);
        chk(16'(core_restart), 16'h0000);
        rd(`PSRPC_PHYCFG_ADDR, 16'h0300);
        mgmt_address_strap = 5'h05;
        wr(`PSRPC_GRC_ADDR, 16'h8000);
        chk(16'(core_reset), 16'h0001);
        repeat (20) @(negedge clk);
        rd(`PSRPC_LEDSEL_ADDR, 16'h0000);
        chk(16'(mgmt_addr), 16'h0013);
        r = rows[7];
        r.adr = 5'h05;
        hwrst(r);
        chk(16'(mgmt_addr), 16'h0005);
        test_done();
    end
endmodule // tb_psrpc_ctrl
bind psrpc_ctrl psrpc_ctrl_asserts i_chk (.*);
`default_nettype wire
